// ==== hw/srmu_move_unit.sv ====
// Execution logic for status, machine state, special and segment register moves
`timescale 1ns/1ps

module srmu_move_unit (
    input wire logic mclk,
    input wire logic rst,
    input wire logic is_64bit,
    input wire srmu_pkg::srmu_instr_s instr_in,
    output logic [31:0] fp_status_control_reg,
    output logic [31:0] machine_state_reg,
    output logic [3:0] cond_field_one,
    output logic cond_field_one_we,
    output srmu_pkg::srmu_spr_wr_s spr_write,
    output srmu_pkg::srmu_sr_wr_s sr_write,
    output srmu_pkg::srmu_exc_s program_exc,
    output logic context_sync
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    // Instruction class from primary and extended opcode
    function automatic srmu_pkg::srmu_kind_e decode_kind(input logic [31:0] w);
        srmu_pkg::srmu_kind_e k;
        k = srmu_pkg::K_NONE;
        if (w[31:26] == srmu_pkg::OP_FP) begin
            case (w[10:1])
                srmu_pkg::XO_FSB1: k = srmu_pkg::K_FSB1;
                srmu_pkg::XO_FSB0: k = srmu_pkg::K_FSB0;
                srmu_pkg::XO_FSF: k = srmu_pkg::K_FSF;
                srmu_pkg::XO_FSFI: k = srmu_pkg::K_FSFI;
                default: k = srmu_pkg::K_NONE;
            endcase
        end else if (w[31:26] == srmu_pkg::OP_INT) begin
            case (w[10:1])
                srmu_pkg::XO_MST: k = srmu_pkg::K_MST;
                srmu_pkg::XO_SPR: k = srmu_pkg::K_SPR;
                srmu_pkg::XO_SR: k = srmu_pkg::K_SR;
                srmu_pkg::XO_SRIN: k = srmu_pkg::K_SRIN;
                default: k = srmu_pkg::K_NONE;
            endcase
        end
        return k;
    endfunction

    // Special register numbers that exist on this core
    function automatic logic spr_defined(input logic [9:0] n);
        logic d;
        d = 1'b0;
        case (n)
            srmu_pkg::SPR_MULQ, srmu_pkg::SPR_FXEX, srmu_pkg::SPR_CLKU,
            srmu_pkg::SPR_CLKL, srmu_pkg::SPR_DCR_U, srmu_pkg::SPR_LINK,
            srmu_pkg::SPR_COUNT: d = 1'b1;
            srmu_pkg::SPR_DSTAT, srmu_pkg::SPR_DADDR, srmu_pkg::SPR_DCR_S,
            srmu_pkg::SPR_PTB, srmu_pkg::SPR_SAVE0, srmu_pkg::SPR_SAVE1,
            srmu_pkg::SPR_EXTACC: d = 1'b1;
            srmu_pkg::SPR_CHKSTOP, srmu_pkg::SPR_DBGMODE, srmu_pkg::SPR_IBRK,
            srmu_pkg::SPR_DBRK, srmu_pkg::SPR_PROCID: d = 1'b1;
            default: begin
                // Scratch block and translation pairs are contiguous ranges
                d = (n >= srmu_pkg::SPR_SCR_LO && n <= srmu_pkg::SPR_SCR_HI)
                    || (n >= srmu_pkg::SPR_BT_LO && n <= srmu_pkg::SPR_BT_HI);
            end
        endcase
        return d;
    endfunction

    // Summary bits and the exception-summary rule after a status change
    function automatic logic [31:0] fp_finish(input logic [31:0] old_v,
                                              input logic [31:0] raw,
                                              input logic direct_fx);
        logic [31:0] r;
        r = raw;
        if (!direct_fx && |((raw & ~old_v) & srmu_pkg::EXC_MASK)) begin
            r[srmu_pkg::ESUM] = 1'b1;
        end
        // Invalid and enabled summaries are always derived, never taken from the source
        r[srmu_pkg::INVSUM] = |(r & srmu_pkg::INV_SUB_MASK);
        r[srmu_pkg::ENSUM] = (r[srmu_pkg::INVSUM] & r[srmu_pkg::VE])
            | (r[srmu_pkg::OVF] & r[srmu_pkg::OE]) | (r[srmu_pkg::UX] & r[srmu_pkg::UE])
            | (r[srmu_pkg::ZX] & r[srmu_pkg::ZE]) | (r[srmu_pkg::XX] & r[srmu_pkg::XE]);
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Operand fields

    srmu_pkg::srmu_state_s st_reg;
    srmu_pkg::srmu_state_s st_next;
    srmu_pkg::srmu_kind_e kind;
    logic [31:0] w;
    logic [4:0] bit_sel;
    logic [2:0] field_sel;
    logic [3:0] nib;
    logic [7:0] fwm;
    logic [31:0] fwm_mask;
    logic [31:0] fi_mask;
    logic [31:0] bit_mask;
    logic [31:0] nib_word;
    logic [9:0] spr_num;
    logic prob;
    logic rec;

    // Instruction bit 0 is the word's msb, so fields read from the top down
    assign w = instr_in.word;
    assign kind = instr_in.valid ? decode_kind(w) : srmu_pkg::K_NONE;
    assign bit_sel = w[25:21];
    assign field_sel = w[25:23];
    assign nib = w[15:12];
    assign fwm = w[24:17];
    assign rec = w[0];
    assign spr_num = {w[15:11], w[20:16]};
    assign prob = st_reg.mst[srmu_pkg::MS_PROB];
    assign bit_mask = srmu_pkg::BIT0_MASK >> bit_sel;
    assign fi_mask = srmu_pkg::FIELD0_MASK >> {field_sel, 2'b00};
    assign nib_word = {8{nib}} & fi_mask;

    // Mask bit i, counted from the top, opens nibble i of the status register
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_fwm
            assign fwm_mask[31-4*gi -: 4] = {4{fwm[7-gi]}};
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    // Pulses drop each cycle; register updates only on a taken move
    always_comb begin
        logic [31:0] fp_new;
        fp_new = st_reg.fpst;
        st_next = st_reg;
        st_next.cf1_we = 1'b0;
        st_next.spr.we = 1'b0;
        st_next.sr.we = 1'b0;
        st_next.exc = '0;
        st_next.ctx_sync = 1'b0;
        case (kind)
            srmu_pkg::K_FSB1: begin
                // Forced bit is ORed after derivation so it always reads one
                fp_new = fp_finish(st_reg.fpst, st_reg.fpst | bit_mask, 1'b0)
                    | bit_mask;
            end
            srmu_pkg::K_FSB0: begin
                if (bit_sel != 5'h01 && bit_sel != 5'h02) begin
                    fp_new = fp_finish(st_reg.fpst, st_reg.fpst & ~bit_mask, 1'b0);
                end
            end
            srmu_pkg::K_FSF: begin
                fp_new = fp_finish(st_reg.fpst,
                    (st_reg.fpst & ~fwm_mask) | (instr_in.fpr_low & fwm_mask),
                    fwm[7]);
            end
            srmu_pkg::K_FSFI: begin
                fp_new = fp_finish(st_reg.fpst,
                    (st_reg.fpst & ~fi_mask) | nib_word,
                    field_sel == 3'h0);
            end
            srmu_pkg::K_MST: begin
                if (prob) begin
                    st_next.exc.priv = 1'b1;
                end else begin
                    st_next.mst = instr_in.gpr_s;
                    st_next.ctx_sync = 1'b1;
                end
            end
            srmu_pkg::K_SPR: begin
                // Problem state plus a supervisor number faults, defined or not
                if (prob && spr_num[4]) begin
                    st_next.exc.priv = 1'b1;
                end else if (spr_defined(spr_num)) begin
                    st_next.spr.we = 1'b1;
                    st_next.spr.num = spr_num;
                    st_next.spr.data = instr_in.gpr_s;
                end
            end
            srmu_pkg::K_SR, srmu_pkg::K_SRIN: begin
                // The illegal form outranks the privilege check
                if (is_64bit) begin
                    st_next.exc.illegal = 1'b1;
                end else if (prob) begin
                    st_next.exc.priv = 1'b1;
                end else begin
                    st_next.sr.we = 1'b1;
                    st_next.sr.idx = (kind == srmu_pkg::K_SR) ? w[19:16]
                        : instr_in.gpr_b[31:28];
                    st_next.sr.data = instr_in.gpr_s;
                end
            end
            default: begin
                st_next.exc = '0;
            end
        endcase
        st_next.fpst = fp_new;
        // Condition field one mirrors the top status nibble after the move
        if (rec && (kind == srmu_pkg::K_FSB1 || kind == srmu_pkg::K_FSB0
                || kind == srmu_pkg::K_FSF || kind == srmu_pkg::K_FSFI)) begin
            st_next.cf1 = fp_new[31:28];
            st_next.cf1_we = 1'b1;
        end
    end

    // Single state register; supervisor state after reset
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
            st_reg.fpst <= srmu_pkg::FPST_RST;
            st_reg.mst <= srmu_pkg::MS_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign fp_status_control_reg = st_reg.fpst;
    assign machine_state_reg = st_reg.mst;
    assign cond_field_one = st_reg.cf1;
    assign cond_field_one_we = st_reg.cf1_we;
    assign spr_write = st_reg.spr;
    assign sr_write = st_reg.sr;
    assign program_exc = st_reg.exc;
    assign context_sync = st_reg.ctx_sync;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    a_bit_set_one: assert property (
        kind == srmu_pkg::K_FSB1 |=> (fp_status_control_reg & $past(bit_mask)) != 0
            && ((fp_status_control_reg ^ $past(fp_status_control_reg)) & 32'h1fff_ffff
                & ~$past(bit_mask)) == 0)
        else $error("bit set disturbed other bits");

    a_summary_kept: assert property (
        kind == srmu_pkg::K_FSB0 && (bit_sel == 5'h01 || bit_sel == 5'h02)
            |=> $stable(fp_status_control_reg))
        else $error("summary bit cleared explicitly");

    a_field_copy: assert property (
        kind == srmu_pkg::K_FSF |=> (fp_status_control_reg & 32'h0fff_ffff)
            == ((($past(fp_status_control_reg) & ~$past(fwm_mask))
            | ($past(instr_in.fpr_low) & $past(fwm_mask))) & 32'h0fff_ffff))
        else $error("field move wrote wrong nibbles");

    a_field0_direct: assert property (
        kind == srmu_pkg::K_FSF && fwm[7] |=>
            fp_status_control_reg[31] == $past(instr_in.fpr_low[31])
            && fp_status_control_reg[28] == $past(instr_in.fpr_low[28]))
        else $error("field 0 summary bits not from source");

    a_sum_on_rise: assert property (
        kind == srmu_pkg::K_FSB1 && (bit_mask & srmu_pkg::EXC_MASK) != 0
            && (st_reg.fpst & bit_mask) == 0 |=> fp_status_control_reg[31])
        else $error("exception summary not set");

    a_nib_field: assert property (
        kind == srmu_pkg::K_FSFI && field_sel != 3'h0 |=>
            (fp_status_control_reg & $past(fi_mask)) == $past(nib_word)
            && (fp_status_control_reg & ~$past(fi_mask) & 32'h0fff_ffff)
            == ($past(fp_status_control_reg) & ~$past(fi_mask) & 32'h0fff_ffff))
        else $error("immediate field move wrong");

    a_nib_field0: assert property (
        kind == srmu_pkg::K_FSFI && field_sel == 3'h0 |=>
            fp_status_control_reg[31] == $past(nib[3])
            && fp_status_control_reg[28] == $past(nib[0]))
        else $error("field 0 immediate bits wrong");

    a_record_cr1: assert property (
        kind inside {srmu_pkg::K_FSF, srmu_pkg::K_FSFI} && rec |=>
            cond_field_one_we && cond_field_one == fp_status_control_reg[31:28])
        else $error("record bit did not update field one");

    a_mstate_write: assert property (
        kind == srmu_pkg::K_MST && !prob |=> machine_state_reg == $past(instr_in.gpr_s)
            && context_sync ##1 !context_sync)
        else $error("machine state write wrong");

    a_spr_priv: assert property (
        kind == srmu_pkg::K_SPR && prob && spr_num[4] |=> program_exc.priv && !spr_write.we)
        else $error("supervisor special write not trapped");

    a_spr_write: assert property (
        kind == srmu_pkg::K_SPR && !prob && spr_defined(spr_num) |=> spr_write.we
            && spr_write.num == {$past(w[15:11]), $past(w[20:16])}
            && spr_write.data == $past(instr_in.gpr_s))
        else $error("special register write wrong");

    a_seg_index: assert property (
        kind == srmu_pkg::K_SRIN && !prob && !is_64bit |=>
            sr_write.we && sr_write.idx == $past(instr_in.gpr_b[31:28]))
        else $error("indirect segment index wrong");

    a_seg_illegal: assert property (
        kind inside {srmu_pkg::K_SR, srmu_pkg::K_SRIN} && is_64bit |=>
            program_exc.illegal && !sr_write.we)
        else $error("segment write on 64-bit not trapped");

    a_fault_quiet: assert property (
        program_exc.priv || program_exc.illegal |-> $stable(machine_state_reg)
            && !spr_write.we && !sr_write.we && !cond_field_one_we)
        else $error("faulting move altered state");

    c_spr_write: cover property (kind == srmu_pkg::K_SPR ##1 spr_write.we);
    c_priv_trap: cover property (kind == srmu_pkg::K_MST ##1 program_exc.priv);
    c_fsf_record: cover property (kind == srmu_pkg::K_FSF && rec && fwm[7]);
    c_seg_write: cover property (kind == srmu_pkg::K_SRIN ##1 sr_write.we);

endmodule

// ==== pkg/srmu_pkg.sv ====
// Package of constants and types for the system register move unit
// Summary of operation
// - Bit-set forces one bit, others unchanged except the summary bits
// - Bits 1 and 2 never explicitly cleared
// - Field move copies masked nibbles from source
// - Field 0: summary and overflow from source
// - Summary set on any exception rise, except on direct field-0 moves
// - Immediate move writes only selected field and the summary bits
// - Field 0 immediate: summary, overflow from nibble
// - Record bit updates condition field one
// - Machine-state write: supervisor only, context sync
// - Register number rebuilt from swapped halves
// - Special register write copies source register
// - Number bit 4 marks supervisor targets
// - Unknown number is no-op unless privileged
// - User special register number decode
// - Supervisor special register number decode
// - Translation and implementation register decode
// - Direct segment write, supervisor only
// - Indirect segment index from index bits
// - Segment writes illegal on 64-bit
package srmu_pkg;

    // Opcode fields
    localparam logic [5:0] OP_FP = 6'h3f;
    localparam logic [5:0] OP_INT = 6'h1f;
    localparam logic [9:0] XO_FSB1 = 10'h026;
    localparam logic [9:0] XO_FSB0 = 10'h046;
    localparam logic [9:0] XO_FSF = 10'h2c7;
    localparam logic [9:0] XO_FSFI = 10'h086;
    localparam logic [9:0] XO_MST = 10'h092;
    localparam logic [9:0] XO_SPR = 10'h1d3;
    localparam logic [9:0] XO_SR = 10'h0d2;
    localparam logic [9:0] XO_SRIN = 10'h0f2;

    // Status register bit positions, little-endian index
    localparam int ESUM = 31;
    localparam int ENSUM = 30;
    localparam int INVSUM = 29;
    localparam int OVF = 28;
    localparam int UX = 27;
    localparam int ZX = 26;
    localparam int XX = 25;
    localparam int VE = 7;
    localparam int OE = 6;
    localparam int UE = 5;
    localparam int ZE = 4;
    localparam int XE = 3;
    localparam logic [31:0] EXC_MASK = 32'h1ff8_0700;
    localparam logic [31:0] INV_SUB_MASK = 32'h01f8_0700;
    localparam logic [31:0] FIELD0_MASK = 32'hf000_0000;
    localparam logic [31:0] BIT0_MASK = 32'h8000_0000;

    // Machine state
    localparam int MS_PROB = 14;
    localparam logic [31:0] MS_RST = 32'h0000_0000;
    localparam logic [31:0] FPST_RST = 32'h0000_0000;

    // Special register numbers
    localparam logic [9:0] SPR_MULQ = 10'h000;
    localparam logic [9:0] SPR_FXEX = 10'h001;
    localparam logic [9:0] SPR_CLKU = 10'h004;
    localparam logic [9:0] SPR_CLKL = 10'h005;
    localparam logic [9:0] SPR_DCR_U = 10'h006;
    localparam logic [9:0] SPR_LINK = 10'h008;
    localparam logic [9:0] SPR_COUNT = 10'h009;
    localparam logic [9:0] SPR_DSTAT = 10'h012;
    localparam logic [9:0] SPR_DADDR = 10'h013;
    localparam logic [9:0] SPR_DCR_S = 10'h016;
    localparam logic [9:0] SPR_PTB = 10'h019;
    localparam logic [9:0] SPR_SAVE0 = 10'h01a;
    localparam logic [9:0] SPR_SAVE1 = 10'h01b;
    localparam logic [9:0] SPR_SCR_LO = 10'h110;
    localparam logic [9:0] SPR_SCR_HI = 10'h113;
    localparam logic [9:0] SPR_EXTACC = 10'h11a;
    localparam logic [9:0] SPR_BT_LO = 10'h210;
    localparam logic [9:0] SPR_BT_HI = 10'h217;
    localparam logic [9:0] SPR_CHKSTOP = 10'h3f0;
    localparam logic [9:0] SPR_DBGMODE = 10'h3f1;
    localparam logic [9:0] SPR_IBRK = 10'h3f2;
    localparam logic [9:0] SPR_DBRK = 10'h3f5;
    localparam logic [9:0] SPR_PROCID = 10'h3ff;

    typedef enum logic [3:0] {
        K_NONE, K_FSB1, K_FSB0, K_FSF, K_FSFI, K_MST, K_SPR, K_SR, K_SRIN
    } srmu_kind_e;

    typedef struct packed {
        logic valid;
        logic [31:0] word;
        logic [31:0] gpr_s;
        logic [31:0] gpr_b;
        logic [31:0] fpr_low;
    } srmu_instr_s;

    typedef struct packed {
        logic we;
        logic [9:0] num;
        logic [31:0] data;
    } srmu_spr_wr_s;

    typedef struct packed {
        logic we;
        logic [3:0] idx;
        logic [31:0] data;
    } srmu_sr_wr_s;

    typedef struct packed {
        logic priv;
        logic illegal;
    } srmu_exc_s;

    typedef struct packed {
        logic [31:0] fpst;
        logic [31:0] mst;
        logic [3:0] cf1;
        logic cf1_we;
        srmu_spr_wr_s spr;
        srmu_sr_wr_s sr;
        srmu_exc_s exc;
        logic ctx_sync;
    } srmu_state_s;

endpackage

// ==== testbench/srmu_move_unit_tb_top.sv ====
// Self-checking testbench for the system register move unit
`timescale 1ns/1ps

module srmu_move_unit_tb_top;

    logic mclk;
    logic rst;
    logic is_64bit;
    srmu_pkg::srmu_instr_s instr_in;
    logic [31:0] fp_status_control_reg;
    logic [31:0] machine_state_reg;
    logic [3:0] cond_field_one;
    logic cond_field_one_we;
    srmu_pkg::srmu_spr_wr_s spr_write;
    srmu_pkg::srmu_sr_wr_s sr_write;
    srmu_pkg::srmu_exc_s program_exc;
    logic context_sync;
    int failures;
    int checks_done;
    logic [31:0] fp_exp;

    srmu_move_unit srmu_move_unit_i (
        .mclk(mclk),
        .rst(rst),
        .is_64bit(is_64bit),
        .instr_in(instr_in),
        .fp_status_control_reg(fp_status_control_reg),
        .machine_state_reg(machine_state_reg),
        .cond_field_one(cond_field_one),
        .cond_field_one_we(cond_field_one_we),
        .spr_write(spr_write),
        .sr_write(sr_write),
        .program_exc(program_exc),
        .context_sync(context_sync)
    );

    // 40 MHz clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Reporting and comparison helpers
    task automatic close_out;
        $display("Summary: %0d mismatches in %0d checks", failures, checks_done);
        if (failures == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    function automatic logic [31:0] mk(input logic [5:0] op, input logic [9:0] xo, input logic rc);
        logic [31:0] w;
        w = 32'h0;
        w[31:26] = op;
        w[10:1] = xo;
        w[0] = rc;
        return w;
    endfunction

    // Reference status update: summaries re-derived, bit 31 set on any exception rise unless field 0 is written directly
    function automatic logic [31:0] fp_model(input logic [31:0] old, input logic [31:0] raw,
                                             input logic direct);
        logic [31:0] r;
        r = raw;
        r[29] = |(r & 32'h01f8_0700);
        r[30] = (r[29] & r[srmu_pkg::VE]) | (r[28] & r[srmu_pkg::OE]) |
                (r[27] & r[srmu_pkg::UE]) | (r[26] & r[srmu_pkg::ZE]) | (r[25] & r[srmu_pkg::XE]);
        if (!direct && |(r & ~old & srmu_pkg::EXC_MASK)) begin
            r[31] = 1'b1;
        end
        return r;
    endfunction

    // Inputs change only at the rising edge; outputs are sampled 1 ns after the taking edge
    task automatic issue(input logic [31:0] w, input logic [31:0] s, input logic [31:0] b,
                         input logic [31:0] f);
        @(posedge mclk);
        instr_in <= '{1'b1, w, s, b, f};
        @(posedge mclk);
        instr_in <= '0;
        #1;
    endtask

    task automatic do_reset;
        @(posedge mclk);
        rst <= 1'b1;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        #1;
        fp_exp = srmu_pkg::FPST_RST;
        chk_word(fp_status_control_reg, 32'h0, "status after reset");
        chk_word(machine_state_reg, 32'h0, "machine state after reset");
    endtask

    task automatic fp_check(input logic [31:0] e, input logic rc);
        chk_word(fp_status_control_reg, e, "fp status");
        chk_bit(cond_field_one_we, rc, "cond field strobe");
        if (rc) begin
            chk_word({28'h0, cond_field_one}, {28'h0, e[31:28]}, "cond field value");
        end
        fp_exp = e;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Status register step tasks
    task automatic bit_step(input logic set, input logic [4:0] n, input logic rc);
        logic [31:0] w;
        logic [31:0] e;
        w = mk(srmu_pkg::OP_FP, set ? srmu_pkg::XO_FSB1 : srmu_pkg::XO_FSB0, rc);
        w[25:21] = n;
        e = set ? (fp_exp | (32'h8000_0000 >> n)) : (fp_exp & ~(32'h8000_0000 >> n));
        e = fp_model(fp_exp, e, 1'b0);
        if (n == 5'h1 || n == 5'h2) begin
            e[31 - n] = set ? 1'b1 : fp_exp[31 - n];
        end
        issue(w, 32'h0, 32'h0, 32'h0);
        fp_check(e, rc);
    endtask

    task automatic fsf_step(input logic [7:0] m, input logic [31:0] v, input logic rc);
        logic [31:0] w;
        logic [31:0] raw;
        w = mk(srmu_pkg::OP_FP, srmu_pkg::XO_FSF, rc);
        w[24:17] = m;
        raw = fp_exp;
        for (int i = 0; i < 8; i++) begin
            if (m[7 - i]) begin
                raw[31 - 4 * i -: 4] = v[31 - 4 * i -: 4];
            end
        end
        issue(w, 32'h0, 32'h0, v);
        fp_check(fp_model(fp_exp, raw, m[7]), rc);
    endtask

    task automatic nib_step(input logic [2:0] f, input logic [3:0] nib, input logic rc);
        logic [31:0] w;
        logic [31:0] raw;
        w = mk(srmu_pkg::OP_FP, srmu_pkg::XO_FSFI, rc);
        w[25:23] = f;
        w[15:12] = nib;
        raw = fp_exp;
        raw[31 - 4 * f -: 4] = nib;
        issue(w, 32'h0, 32'h0, 32'h0);
        fp_check(fp_model(fp_exp, raw, f == 3'h0), rc);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Special and segment register step tasks
    task automatic spr_step(input logic [9:0] num, input logic [31:0] d, input logic ok,
                            input logic priv);
        logic [31:0] w;
        w = mk(srmu_pkg::OP_INT, srmu_pkg::XO_SPR, 1'b0);
        w[20:16] = num[4:0];
        w[15:11] = num[9:5];
        issue(w, d, 32'h0, 32'h0);
        chk_bit(spr_write.we, ok, "special write strobe");
        chk_bit(program_exc.priv, priv, "privilege trap");
        if (ok) begin
            chk_word({22'h0, spr_write.num}, {22'h0, num}, "special number");
            chk_word(spr_write.data, d, "special data");
        end
    endtask

    task automatic sr_step(input logic ind, input logic [3:0] idx, input logic ok,
                           input logic priv, input logic ill);
        logic [31:0] w;
        logic [31:0] b;
        w = mk(srmu_pkg::OP_INT, ind ? srmu_pkg::XO_SRIN : srmu_pkg::XO_SR, 1'b0);
        b = 32'h0abc_def1;
        // Indirect form gets a decoy in the direct field to catch a wrong source
        w[19:16] = ind ? ~idx : idx;
        b[31:28] = ind ? idx : ~idx;
        issue(w, {28'h5a5a_c3c, idx}, b, 32'h0);
        chk_bit(sr_write.we, ok, "segment strobe");
        chk_bit(program_exc.priv, priv, "segment privilege");
        chk_bit(program_exc.illegal, ill, "segment illegal");
        if (ok) begin
            chk_word({28'h0, sr_write.idx}, {28'h0, idx}, "segment index");
            chk_word(sr_write.data, {28'h5a5a_c3c, idx}, "segment data");
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_status_moves;
        bit_step(1'b1, 5'd3, 1'b1);
        bit_step(1'b1, 5'd24, 1'b0);
        bit_step(1'b1, 5'd7, 1'b1);
        bit_step(1'b1, 5'd2, 1'b0);
        bit_step(1'b1, 5'd0, 1'b1);
        bit_step(1'b0, 5'd1, 1'b0);
        bit_step(1'b0, 5'd2, 1'b0);
        bit_step(1'b0, 5'd7, 1'b1);
        do_reset();
        fsf_step(8'h80, 32'h7000_0000, 1'b1);
        fsf_step(8'h40, 32'h0f00_0000, 1'b0);
        fsf_step(8'h01, 32'h0000_000f, 1'b1);
        fsf_step(8'hff, 32'h0000_00f8, 1'b0);
        for (int i = 7; i > 0; i--) begin
            nib_step(3'(i), 4'(i) ^ 4'h6, i[0]);
        end
        nib_step(3'h0, 4'h9, 1'b1);
        nib_step(3'h0, 4'h0, 1'b0);
        nib_step(3'h0, 4'h1, 1'b1);
    endtask

    task automatic t_special;
        int nums[31] = '{0, 1, 4, 5, 6, 8, 9, 18, 19, 22, 25, 26, 27, 272, 273, 274, 275, 282,
                         528, 529, 530, 531, 532, 533, 534, 535, 1008, 1009, 1010, 1013, 1023};
        int bad[6] = '{2, 7, 16, 20, 21, 287};
        foreach (nums[k]) begin
            spr_step(10'(nums[k]), 32'hc000_0000 + 32'(k), 1'b1, 1'b0);
        end
        foreach (bad[k]) begin
            spr_step(10'(bad[k]), 32'h1111_0000, 1'b0, 1'b0);
        end
        // Back to back: each cycle shows its own instruction
        @(posedge mclk);
        instr_in <= '{1'b1, mk(srmu_pkg::OP_INT, srmu_pkg::XO_SPR, 1'b0) | 32'h0008_0000,
                      32'h0000_aaaa, 32'h0, 32'h0};
        @(posedge mclk);
        instr_in <= '{1'b1, mk(srmu_pkg::OP_INT, srmu_pkg::XO_SPR, 1'b0) | 32'h0009_0000,
                      32'h0000_bbbb, 32'h0, 32'h0};
        #1;
        chk_word(spr_write.data, 32'h0000_aaaa, "first of pair");
        @(posedge mclk);
        instr_in <= '0;
        #1;
        chk_word({21'h0, spr_write.num, spr_write.data[0]}, {21'h0, 10'd9, 1'b1}, "second");
    endtask

    task automatic t_segment;
        for (int i = 0; i < 16; i++) begin
            sr_step(1'b0, 4'(i), 1'b1, 1'b0, 1'b0);
            sr_step(1'b1, 4'(i), 1'b1, 1'b0, 1'b0);
        end
        @(posedge mclk);
        is_64bit <= 1'b1;
        sr_step(1'b0, 4'h5, 1'b0, 1'b0, 1'b1);
        sr_step(1'b1, 4'ha, 1'b0, 1'b0, 1'b1);
        @(posedge mclk);
        is_64bit <= 1'b0;
    endtask

    task automatic t_problem_state;
        logic [31:0] w;
        w = mk(srmu_pkg::OP_INT, 10'h092, 1'b0);
        do_reset();
        issue(w, 32'ha5a5_4000, 32'h0, 32'h0);
        chk_word(machine_state_reg, 32'ha5a5_4000, "machine state load");
        chk_bit(context_sync, 1'b1, "sync pulse");
        issue(w, 32'h0, 32'h0, 32'h0);
        chk_word(machine_state_reg, 32'ha5a5_4000, "machine state kept");
        chk_bit(context_sync, 1'b0, "no sync on trap");
        chk_bit(program_exc.priv, 1'b1, "machine state trap");
        spr_step(10'd22, 32'h2222_2222, 1'b0, 1'b1);
        spr_step(10'd1013, 32'h2222_2222, 1'b0, 1'b1);
        spr_step(10'd8, 32'h3333_3333, 1'b1, 1'b0);
        spr_step(10'd16, 32'h4444_4444, 1'b0, 1'b1);
        spr_step(10'd2, 32'h4444_4444, 1'b0, 1'b0);
        sr_step(1'b0, 4'h3, 1'b0, 1'b1, 1'b0);
        @(posedge mclk);
        is_64bit <= 1'b1;
        sr_step(1'b1, 4'h3, 1'b0, 1'b0, 1'b1);
        chk_word(fp_status_control_reg, fp_exp, "status untouched by traps");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial begin
        rst = 1'b1;
        is_64bit = 1'b0;
        instr_in = '0;
        failures = 0;
        checks_done = 0;
        fp_exp = 32'h0;
        do_reset();
        t_status_moves();
        t_special();
        t_segment();
        t_problem_state();
        close_out();
    end

    // Whole run is well under a thousand cycles; allow a wide margin
    initial begin
        #(25 * 5000);
        failures++;
        $display("BAD %0t watchdog expired", $time);
        close_out();
    end

endmodule
